// >>> rtl/iars_pkg.sv
// Constants and types of the interrupt accept and return sequencer.
// Assumes one machine-cycle clock and an APB register port.
`default_nettype none
package iars_pkg;
   // ****************************************
   // Sizes and timing
   // ****************************************
   localparam int NUM_SRC = 8;
   localparam int SRC_W = 3;
   localparam int ACCEPT_CYCLES = 12;
   localparam int WORST_LAT_FC = 62;
   localparam int FC_PER_CYCLE = 4;
   localparam int WORST_LAT_CYCLES = WORST_LAT_FC / FC_PER_CYCLE;
   localparam int PUSH_BYTES = 5;
   localparam logic [7:0] TRAP_OPCODE = 8'hff;
   localparam logic [SRC_W-1:0] SWI_SRC = 3'h0;
   localparam logic [SRC_W-1:0] NMI_SRC = 3'h1;
   // ****************************************
   // Register offsets and resets
   // ****************************************
   localparam logic [7:0] REG_LATCH = 8'h00;
   localparam logic [7:0] REG_ENABLE = 8'h04;
   localparam logic [7:0] REG_CTRL = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;
   localparam logic [7:0] REG_SP = 8'h10;
   localparam int CTRL_MIE_BIT = 0;
   localparam int CTRL_SINGLE_BIT = 1;
   localparam logic [15:0] SP_RESET = 16'h0100;
   localparam logic [1:0] NEST_CLEAR = 2'h1;
   localparam logic [1:0] NEST_DOWN = 2'h2;
   typedef enum logic [1:0]
   {
      ST_RUN = 2'b00,
      ST_ACCEPT = 2'b01
   } iars_state_type;
endpackage : iars_pkg
`default_nettype wire

// >>> rtl/iars_req_if.sv
// Request path between the latch block and the sequencer.
// Assumes both ends share core_clk.
`default_nettype none
interface iars_req_if;
   logic [iars_pkg::NUM_SRC-1:0] pending;
   logic [iars_pkg::NUM_SRC-1:0] ack;
   logic [iars_pkg::NUM_SRC-1:0] sw_clr;
   logic sw_clr_we;
   logic [iars_pkg::NUM_SRC-1:0] latch;
   modport latch_side (output pending, output latch, input ack, input sw_clr, input sw_clr_we);
   modport seq_side (input pending, input latch, output ack, output sw_clr, output sw_clr_we);
endinterface : iars_req_if
`default_nettype wire

// >>> rtl/iars_latch.sv
// Request latches, one per source.
// Assumes request pulses synchronous to core_clk.
`default_nettype none
module iars_latch
#(
   parameter int N = iars_pkg::NUM_SRC
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [N-1:0] src_req,
   input wire logic [N-1:0] enable,
   iars_req_if.latch_side req
);
   logic [N-1:0] request_latch_q;
   genvar i;
   generate
      for (i = 0; i < N; i++)
      begin : g_lat
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
               request_latch_q[i] <= 1'b0;
            else if (src_req[i])
               request_latch_q[i] <= 1'b1;
            else if (req.ack[i] || (req.sw_clr_we && !req.sw_clr[i]))
               request_latch_q[i] <= 1'b0;
         end
      end
   endgenerate
   logic [N-1:0] must_keep;
   assign req.latch = request_latch_q;
   assign req.pending = request_latch_q & enable;
   // Raised bits that neither an ack nor a software clear may drop
   assign must_keep = request_latch_q & ~req.ack & ~({N{req.sw_clr_we}} & ~req.sw_clr);
   a_latch_hold: assert property (@(posedge clk) disable iff (!rst_n)
      (request_latch_q & $past(must_keep)) == $past(must_keep))
      else $error("latch dropped");
endmodule : iars_latch
`default_nettype wire

// >>> rtl/iars_top.sv
// Interrupt accept and return sequencer with APB registers.
// Assumes the pipeline flags boundaries, returns and fetches.
`default_nettype none
module iars_top
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [iars_pkg::NUM_SRC-1:0] src_req,
   input wire logic instr_last,
   input wire logic [7:0] fetch_opcode,
   input wire logic fetch_valid,
   input wire logic fetch_missing,
   input wire logic fetch_in_data_area,
   input wire logic ret_maskable,
   input wire logic ret_nonmaskable,
   input wire logic [23:0] pc_in,
   input wire logic [15:0] psw_in,
   input wire logic [15:0] pop_psw,
   input wire logic [23:0] pop_pc,
   input wire logic [23:0] vec_entry,
   input wire logic [7:0] vec_bank,
   output logic [iars_pkg::SRC_W-1:0] vec_src,
   output logic accept_busy,
   output logic push_we,
   output logic [7:0] push_data,
   output logic [15:0] push_addr,
   output logic pc_load,
   output logic [23:0] pc_out,
   output logic [3:0] register_bank_selector,
   output logic master_irq_enable,
   output logic [1:0] nesting_status_flag,
   output logic address_error,
   output logic trap_reset
);
   // ****************************************
   // Reset release
   // ****************************************
   logic rst_s1_q;
   logic rst_n;
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_s1_q <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_n <= rst_s1_q;
      end
   end
   // ****************************************
   // Registers and bus
   // ****************************************
   logic [iars_pkg::NUM_SRC-1:0] enable_q;
   logic mie_q;
   logic single_chip_q;
   logic [15:0] sp_q;
   logic [3:0] nest_q;
   logic [3:0] bank_q;
   logic nmi_active_q;
   logic [23:0] pc_q;
   logic [15:0] psw_q;
   iars_pkg::iars_state_type state_q;
   logic [3:0] cyc_q;
   logic [iars_pkg::SRC_W-1:0] src_q;
   logic swi_q;
   logic wr;
   logic rd_ok;
   logic sel_latch;
   logic sel_enable;
   logic sel_ctrl;
   logic sel_status;
   logic sel_sp;
   iars_req_if req ();
   assign wr = psel && penable && pwrite;
   assign sel_latch = paddr == iars_pkg::REG_LATCH;
   assign sel_enable = paddr == iars_pkg::REG_ENABLE;
   assign sel_ctrl = paddr == iars_pkg::REG_CTRL;
   assign sel_status = paddr == iars_pkg::REG_STATUS;
   assign sel_sp = paddr == iars_pkg::REG_SP;
   assign rd_ok = sel_latch || sel_enable || sel_ctrl || sel_status || sel_sp;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !rd_ok;
   assign req.sw_clr = pwdata[iars_pkg::NUM_SRC-1:0];
   assign req.sw_clr_we = wr && sel_latch;
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         prdata <= 32'h0;
      else if (psel && !penable && !pwrite)
      begin
         if (sel_latch)
            prdata <= {24'h0, req.latch};
         else if (sel_enable)
            prdata <= {24'h0, enable_q};
         else if (sel_ctrl)
            prdata <= {30'h0, single_chip_q, mie_q};
         else if (sel_status)
            prdata <= {24'h0, bank_q, 2'h0, nesting_status_flag};
         else if (sel_sp)
            prdata <= {16'h0, sp_q};
         else
            prdata <= 32'h0;
      end
   end
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         enable_q <= '0;
         single_chip_q <= 1'b1;
      end
      else if (wr && sel_enable)
         enable_q <= pwdata[iars_pkg::NUM_SRC-1:0];
      else if (wr && sel_ctrl)
         single_chip_q <= pwdata[iars_pkg::CTRL_SINGLE_BIT];
   end
   iars_latch #(.N(iars_pkg::NUM_SRC)) u_latch
   (
      .clk(core_clk),
      .rst_n(rst_n),
      .src_req(src_req),
      .enable(enable_q),
      .req(req)
   );
   // ****************************************
   // Trap and priority
   // ****************************************
   logic trap_op;
   logic swi_fire;
   logic nmi_pend;
   logic mask_any;
   logic [iars_pkg::SRC_W-1:0] mask_src;
   logic take;
   assign trap_op = fetch_valid && (fetch_missing && single_chip_q
      || fetch_opcode == iars_pkg::TRAP_OPCODE);
   assign swi_fire = trap_op && !nmi_active_q;
   assign trap_reset = fetch_valid && fetch_in_data_area;
   assign nmi_pend = req.latch[iars_pkg::NMI_SRC];
   always_comb
   begin
      mask_any = 1'b0;
      mask_src = '0;
      for (int k = iars_pkg::NUM_SRC - 1; k > 1; k--)
      begin
         if (req.pending[k])
         begin
            mask_any = 1'b1;
            mask_src = k[iars_pkg::SRC_W-1:0];
         end
      end
   end
   assign take = state_q == iars_pkg::ST_RUN && instr_last
      && (swi_fire || nmi_pend || mask_any && mie_q);
   // ****************************************
   // Acceptance sequencer
   // ****************************************
   logic [2:0] push_idx;
   logic [iars_pkg::NUM_SRC-1:0] ack_d;
   assign push_idx = 3'(cyc_q - 4'h1);
   genvar a;
   generate
      for (a = 0; a < iars_pkg::NUM_SRC; a++)
      begin : g_ack
         assign ack_d[a] = state_q == iars_pkg::ST_ACCEPT && cyc_q == 4'h0 && !swi_q
            && int'(src_q) == a;
      end
   endgenerate
   assign req.ack = ack_d;
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= iars_pkg::ST_RUN;
         cyc_q <= 4'h0;
         src_q <= '0;
         swi_q <= 1'b0;
      end
      else if (take)
      begin
         state_q <= iars_pkg::ST_ACCEPT;
         cyc_q <= 4'h0;
         swi_q <= swi_fire;
         src_q <= swi_fire ? iars_pkg::SWI_SRC : nmi_pend ? iars_pkg::NMI_SRC : mask_src;
      end
      else if (state_q == iars_pkg::ST_ACCEPT)
      begin
         cyc_q <= cyc_q + 4'h1;
         if (cyc_q == 4'(iars_pkg::ACCEPT_CYCLES - 1))
            state_q <= iars_pkg::ST_RUN;
      end
   end
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pc_q <= 24'h0;
         psw_q <= 16'h0;
      end
      else if (take)
      begin
         pc_q <= pc_in;
         psw_q <= {psw_in[15:12], bank_q, psw_in[7:1], mie_q};
      end
   end
   always_comb
   begin
      push_data = 8'h0;
      case (push_idx)
         3'h0: push_data = psw_q[15:8];
         3'h1: push_data = psw_q[7:0];
         3'h2: push_data = pc_q[23:16];
         3'h3: push_data = pc_q[15:8];
         default: push_data = pc_q[7:0];
      endcase
   end
   assign push_we = state_q == iars_pkg::ST_ACCEPT && cyc_q >= 4'h1
      && cyc_q <= 4'(iars_pkg::PUSH_BYTES);
   assign push_addr = sp_q;
   assign accept_busy = state_q == iars_pkg::ST_ACCEPT;
   assign vec_src = src_q;
   assign pc_load = state_q == iars_pkg::ST_ACCEPT && cyc_q == 4'(iars_pkg::ACCEPT_CYCLES - 1)
      || ret_maskable || ret_nonmaskable;
   assign pc_out = accept_busy ? vec_entry : pop_pc;
   logic acc_end;
   logic ret_any;
   assign acc_end = state_q == iars_pkg::ST_ACCEPT
      && cyc_q == 4'(iars_pkg::ACCEPT_CYCLES - 1);
   assign ret_any = !accept_busy && (ret_maskable || ret_nonmaskable);
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sp_q <= iars_pkg::SP_RESET;
         mie_q <= 1'b0;
         bank_q <= 4'h0;
         nest_q <= 4'h0;
         nmi_active_q <= 1'b0;
      end
      else
      begin
         if (wr && sel_sp)
            sp_q <= pwdata[15:0];
         else if (push_we)
            sp_q <= sp_q - 16'h1;
         else if (ret_any)
            sp_q <= sp_q + 16'(iars_pkg::PUSH_BYTES);
         if (take)
            mie_q <= 1'b0;
         else if (ret_maskable && !accept_busy)
            mie_q <= 1'b1;
         else if (ret_nonmaskable && !accept_busy)
            mie_q <= pop_psw[0];
         else if (wr && sel_ctrl)
            mie_q <= pwdata[iars_pkg::CTRL_MIE_BIT];
         if (acc_end)
            bank_q <= bank_q + vec_bank[7:4];
         else if (ret_any)
            bank_q <= pop_psw[11:8];
         if (acc_end)
            nest_q <= nest_q + 4'h1;
         else if (ret_any || wr && sel_status && pwdata[1:0] == iars_pkg::NEST_DOWN)
            nest_q <= nest_q - 4'h1;
         else if (wr && sel_status && pwdata[1:0] == iars_pkg::NEST_CLEAR)
            nest_q <= 4'h0;
         if (acc_end && src_q == iars_pkg::NMI_SRC && !swi_q)
            nmi_active_q <= 1'b1;
         else if (ret_nonmaskable && !accept_busy)
            nmi_active_q <= 1'b0;
      end
   end
   assign nesting_status_flag = nest_q == 4'h0 ? 2'h0 : nest_q == 4'h1 ? 2'h1
      : nest_q == 4'h2 ? 2'h2 : 2'h3;
   assign register_bank_selector = bank_q;
   assign master_irq_enable = mie_q;
   assign address_error = take && swi_fire && fetch_missing;
   // ****************************************
   // Checks
   // ****************************************
   a_accept_len: assert property (@(posedge core_clk) disable iff (!rst_n)
      take |=> accept_busy [*8] ##1 accept_busy [*4] ##1 !accept_busy)
      else $error("accept length wrong");
   a_mie_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
      take |=> !mie_q)
      else $error("enable not cleared");
   a_sp_push: assert property (@(posedge core_clk) disable iff (!rst_n)
      take && !(wr && sel_sp) |=> ##6 sp_q == $past(sp_q, 6) - 16'h5)
      else $error("stack not down five");
   a_nest_up: assert property (@(posedge core_clk) disable iff (!rst_n)
      acc_end && nest_q != 4'hf |=> nest_q == $past(nest_q) + 4'h1)
      else $error("nest not up");
   a_mask_block: assert property (@(posedge core_clk) disable iff (!rst_n)
      take && !mie_q |-> swi_fire || nmi_pend)
      else $error("masked accepted");
   a_maskable_return_op_mie: assert property (@(posedge core_clk) disable iff (!rst_n)
      ret_maskable && !accept_busy && !take |=> mie_q)
      else $error("enable not set");
   a_nonmaskable_return_op_mie: assert property (@(posedge core_clk) disable iff (!rst_n)
      ret_nonmaskable && !accept_busy && !take |=> mie_q == $past(pop_psw[0]))
      else $error("nonmaskable_return_op enable wrong");
   a_swi_nop: assert property (@(posedge core_clk) disable iff (!rst_n)
      nmi_active_q |-> !swi_fire)
      else $error("trap in nmi");
   a_trap_rst: assert property (@(posedge core_clk) disable iff (!rst_n)
      fetch_valid && fetch_in_data_area |-> trap_reset)
      else $error("no trap reset");
   c_accept: cover property (@(posedge core_clk) disable iff (!rst_n) take ##13 !accept_busy);
   c_swi: cover property (@(posedge core_clk) disable iff (!rst_n) take && swi_fire);
   c_maskable_return_op: cover property (@(posedge core_clk) disable iff (!rst_n) ret_maskable && nest_q != 0);
endmodule : iars_top
`default_nettype wire

// >>> dv/iars_partner.sv
// Far-side model: byte stack for pushes and pops, and the vector table.
// Assumes one push byte per cycle and pops only after whole frames.
`default_nettype none
module iars_partner
(
   input wire logic clk,
   input wire logic push_we,
   input wire logic [7:0] push_data,
   input wire logic pop,
   input wire logic [iars_pkg::SRC_W-1:0] vec_src,
   output logic [23:0] vec_entry,
   output logic [7:0] vec_bank,
   output logic [15:0] pop_psw,
   output logic [23:0] pop_pc
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] stk[$];
   int n;
   assign vec_entry = 24'h008000 + {17'h0, vec_src, 4'h0};
   assign vec_bank = {1'b0, vec_src, 4'h5};
   initial
   begin
      pop_psw = 16'h0;
      pop_pc = 24'h0;
   end
   always @(posedge clk)
   begin
      if (push_we === 1'b1)
         stk.push_back(push_data);
      if (pop === 1'b1 && stk.size() >= 5)
         repeat (5) void'(stk.pop_back());
      n = stk.size();
      if (n >= 5)
      begin
         pop_psw <= {stk[n-5], stk[n-4]};
         pop_pc <= {stk[n-3], stk[n-2], stk[n-1]};
      end
      else
      begin
         pop_psw <= ~pop_psw;
         pop_pc <= ~pop_pc;
      end
   end
endmodule : iars_partner
`default_nettype wire

// >>> dv/iars_top_test.sv
// Self-checking bench for the interrupt accept and return sequencer.
// Assumes the partner model as stack memory and vector table.
`default_nettype none
module iars_top_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, fetch_opcode = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [iars_pkg::NUM_SRC-1:0] src_req = 8'h00;
   logic instr_last = 1'b0, fetch_valid = 1'b0, fetch_missing = 1'b0;
   logic fetch_in_data_area = 1'b0, ret_maskable = 1'b0, ret_nonmaskable = 1'b0;
   logic [23:0] pc_in = 24'h0, pop_pc, vec_entry, pc_out;
   logic [15:0] psw_in = 16'h0, pop_psw, push_addr;
   logic [31:0] prdata, rd;
   logic pready, pslverr, accept_busy, push_we, pc_load, er;
   logic master_irq_enable, address_error, trap_reset;
   logic [7:0] vec_bank, push_data;
   logic [iars_pkg::SRC_W-1:0] vec_src;
   logic [3:0] register_bank_selector, ebank;
   logic [1:0] nesting_status_flag;
   logic [7:0] pushq[$];
   logic [15:0] pusha[$];
   logic [23:0] spc[$];
   logic [15:0] spsw[$];
   logic [15:0] esp;
   int n_fail, num_checks, lvl, nae, ntr, s;
   iars_top dut (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .src_req(src_req), .instr_last(instr_last),
      .fetch_opcode(fetch_opcode), .fetch_valid(fetch_valid), .fetch_missing(fetch_missing),
      .fetch_in_data_area(fetch_in_data_area), .ret_maskable(ret_maskable),
      .ret_nonmaskable(ret_nonmaskable), .pc_in(pc_in), .psw_in(psw_in), .pop_psw(pop_psw),
      .pop_pc(pop_pc), .vec_entry(vec_entry), .vec_bank(vec_bank), .vec_src(vec_src),
      .accept_busy(accept_busy), .push_we(push_we), .push_data(push_data),
      .push_addr(push_addr), .pc_load(pc_load), .pc_out(pc_out),
      .register_bank_selector(register_bank_selector), .master_irq_enable(master_irq_enable),
      .nesting_status_flag(nesting_status_flag), .address_error(address_error),
      .trap_reset(trap_reset));
   iars_partner model (.clk(core_clk), .push_we(push_we), .push_data(push_data),
      .pop(ret_maskable | ret_nonmaskable), .vec_src(vec_src), .vec_entry(vec_entry),
      .vec_bank(vec_bank), .pop_psw(pop_psw), .pop_pc(pop_pc));
   // ********
   // Clock, monitors and helpers
   // ********
   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
   begin
      if (push_we === 1'b1)
      begin
         pushq.push_back(push_data);
         pusha.push_back(push_addr);
      end
      if (address_error === 1'b1)
         nae++;
      if (trap_reset === 1'b1)
         ntr++;
   end
   function automatic logic [1:0] nc(input int l);
      return (l > 3) ? 2'h3 : 2'(l);
   endfunction : nc
   task complete_run;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : complete_run
   task chk(input string nm, input logic [39:0] e, input logic [39:0] g);
      num_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge core_clk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task req(input logic [7:0] m);
      @(posedge core_clk);
      src_req <= m;
      @(posedge core_clk);
      src_req <= 8'h00;
   endtask : req
   task noacc(input logic [7:0] op);
      int nb;
      @(posedge core_clk);
      fetch_opcode <= op;
      fetch_valid <= 1'b1;
      instr_last <= 1'b1;
      @(posedge core_clk);
      instr_last <= 1'b0;
      fetch_valid <= 1'b0;
      nb = 0;
      repeat (4)
      begin
         #1;
         if (accept_busy !== 1'b0)
            nb++;
         @(posedge core_clk);
      end
      chk("busy", 0, nb);
   endtask : noacc
   task accept(input int s, input logic [7:0] op, input logic miss, input logic m);
      logic [23:0] pc, lp;
      logic [15:0] program_status_word, sv;
      int nb, at;
      pc = 24'($urandom);
      program_status_word = 16'($urandom);
      pushq.delete();
      pusha.delete();
      @(posedge core_clk);
      pc_in <= pc;
      psw_in <= program_status_word;
      fetch_opcode <= op;
      fetch_missing <= miss;
      fetch_valid <= 1'b1;
      instr_last <= 1'b1;
      @(posedge core_clk);
      instr_last <= 1'b0;
      fetch_missing <= 1'b0;
      fetch_valid <= 1'b0;
      nb = 0;
      at = 0;
      repeat (14)
      begin
         #1;
         if (accept_busy === 1'b1)
            nb++;
         if (pc_load === 1'b1)
         begin
            at = nb;
            lp = pc_out;
         end
         @(posedge core_clk);
      end
      #1;
      chk("busy cycles", 12, nb);
      chk("load cycle", 12, at);
      chk("entry", 24'h008000 + 24'(s) * 24'h10, lp);
      chk("source", s, vec_src);
      chk("enable", 0, master_irq_enable);
      sv = {program_status_word[15:12], ebank, program_status_word[7:1], m};
      chk("push", {sv, pc}, {pushq[0], pushq[1], pushq[2], pushq[3], pushq[4]});
      chk("push addr", {esp, esp - 16'h4}, {pusha[0], pusha[4]});
      ebank = ebank + 4'(s);
      chk("bank", ebank, register_bank_selector);
      lvl++;
      chk("nest", nc(lvl), nesting_status_flag);
      spsw.push_back(sv);
      spc.push_back(pc);
      esp = esp - 16'h5;
      apb(1'b0, iars_pkg::REG_SP, 32'h0);
      chk("sp", esp, rd);
   endtask : accept
   task ret(input logic nm);
      logic [15:0] p;
      logic [23:0] rp;
      p = spsw.pop_back();
      rp = spc.pop_back();
      @(posedge core_clk);
      ret_maskable <= ~nm;
      ret_nonmaskable <= nm;
      #1;
      chk("ret pc", {1'b1, rp}, {pc_load, pc_out});
      @(posedge core_clk);
      ret_maskable <= 1'b0;
      ret_nonmaskable <= 1'b0;
      #1;
      chk("ret enable", nm ? p[0] : 1'b1, master_irq_enable);
      ebank = p[11:8];
      chk("ret bank", ebank, register_bank_selector);
      lvl--;
      chk("ret nest", nc(lvl), nesting_status_flag);
      esp = esp + 16'h5;
      apb(1'b0, iars_pkg::REG_SP, 32'h0);
      chk("ret sp", esp, rd);
   endtask : ret
   // ********
   // Main sequence and watchdog
   // ********
   initial
   begin
      repeat (20000) @(posedge core_clk);
      n_fail++;
      complete_run;
   end
   initial
   begin
      void'($urandom(32'h5766));
      esp = iars_pkg::SP_RESET;
      ebank = 4'h0;
      repeat (4) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge core_clk);
      apb(1'b0, iars_pkg::REG_SP, 32'h0);
      chk("sp reset", iars_pkg::SP_RESET, rd);
      apb(1'b0, iars_pkg::REG_CTRL, 32'h0);
      chk("ctrl reset", 32'h1 << iars_pkg::CTRL_SINGLE_BIT, rd);
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped", 33'h0, {er ^ 1'b1, rd});
      apb(1'b1, iars_pkg::REG_ENABLE, 32'h28);
      apb(1'b1, iars_pkg::REG_CTRL, 32'h3);
      req(8'h68);
      apb(1'b1, iars_pkg::REG_LATCH, 32'h28);
      apb(1'b0, iars_pkg::REG_LATCH, 32'h0);
      chk("latch", 32'h28, rd);
      accept(3, 8'h00, 1'b0, 1'b1);
      apb(1'b0, iars_pkg::REG_LATCH, 32'h0);
      chk("latch", 32'h20, rd);
      noacc(8'h00);
      ret(1'b0);
      accept(5, 8'h00, 1'b0, 1'b1);
      apb(1'b1, iars_pkg::REG_ENABLE, 32'h10);
      apb(1'b1, iars_pkg::REG_CTRL, 32'h3);
      req(8'h10);
      accept(4, 8'h00, 1'b0, 1'b1);
      ret(1'b0);
      ret(1'b0);
      repeat (4)
      begin
         s = 2 + int'($urandom % 6);
         apb(1'b1, iars_pkg::REG_ENABLE, 32'h1 << s);
         req(8'h1 << s);
         accept(s, 8'h00, 1'b0, 1'b1);
         ret(1'b0);
      end
      req(8'h02);
      accept(1, 8'h00, 1'b0, 1'b1);
      noacc(8'hff);
      ret(1'b1);
      apb(1'b1, iars_pkg::REG_CTRL, 32'h2);
      req(8'h02);
      accept(1, 8'h00, 1'b0, 1'b0);
      ret(1'b1);
      apb(1'b1, iars_pkg::REG_CTRL, 32'h3);
      accept(0, 8'hff, 1'b0, 1'b1);
      ret(1'b0);
      accept(0, 8'h00, 1'b1, 1'b1);
      chk("addr error", 1'b1, nae != 0);
      ret(1'b0);
      @(posedge core_clk);
      fetch_valid <= 1'b1;
      fetch_in_data_area <= 1'b1;
      @(posedge core_clk);
      fetch_valid <= 1'b0;
      fetch_in_data_area <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk("trap reset", 1'b1, ntr != 0);
      complete_run;
   end
endmodule : iars_top_test
`default_nettype wire
